// [core/buck_group_ctrl.sv]
// buck group control: APB registers, grouping steer, set-point select and decode
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
module buck_group_ctrl
  import buck_group_pkg::*;
(
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // apb slave
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [7:0]   i_paddr,
  input  wire logic [31:0]  i_pwdata,
  output logic [31:0]       o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  // device state pins
  input  wire logic [1:0]   i_grouping_select,
  input  wire logic         i_standby,
  input  wire logic         i_sleep,
  // node drive
  output logic              o_pair_node_first,
  output logic              o_pair_node_second,
  output logic              o_third_node,
  output node_drive_t       o_pair_drive,
  output node_drive_t       o_third_drive,
  // regulation targets
  output logic [5:0]        o_pair_setpoint,
  output logic [5:0]        o_third_setpoint,
  output logic [10:0]       o_pair_target_mv,
  output logic [10:0]       o_third_target_mv,
  output logic              o_pair_enable,
  output logic              o_third_enable,
  output logic [5:0]        o_pair_mode,
  output logic [5:0]        o_third_mode
);

  // ==========================================
  // pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  // no reset: the strap must already sit in the second stage when capture runs after release
  always_ff @(posedge i_ref_clk)
  begin
    pin_s1_r <= {i_grouping_select, i_standby, i_sleep};
    pin_s2_r <= pin_s1_r;
  end

  // one-time field: caught once after reset, then frozen
  logic      grp_seen_r;
  logic      grp_seen_nxt;
  logic      load_cnt_r;
  logic      load_cnt_nxt;
  grouping_t grp_r;
  grouping_t grp_nxt;
  always_comb
  begin
    load_cnt_nxt = 1'b1;
    grp_seen_nxt = grp_seen_r | load_cnt_r;
    grp_nxt      = (load_cnt_r && !grp_seen_r) ? grouping_t'(pin_s2_r[3:2]) : grp_r;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      load_cnt_r <= 1'b0;
      grp_seen_r <= 1'b0;
      grp_r      <= GRP_ALL_ONE;
    end
    else
    begin
      load_cnt_r <= load_cnt_nxt;
      grp_seen_r <= grp_seen_nxt;
      grp_r      <= grp_nxt;
    end
  end

  // ==========================================
  // registers
  logic [5:0]        sp_r  [6];   // pair n/s/z, third n/s/z
  logic [5:0]        sp_nxt[6];
  logic [5:0]        mode_r   [2];
  logic [5:0]        mode_nxt [2];
  switching_config_t conf_r   [2];
  switching_config_t conf_nxt [2];
  logic [1:0]        en_r;
  logic [1:0]        en_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic              ready_r;
  logic              ready_nxt;
  logic              err_r;
  logic              err_nxt;
  logic              wr;
  logic              acc;
  logic              hit;

  localparam logic [7:0] SP_OFS [6] = '{OFS_PAIR_NORM, OFS_PAIR_STBY, OFS_PAIR_SLEEP,
                                        OFS_THRD_NORM, OFS_THRD_STBY, OFS_THRD_SLEEP};
  localparam logic [7:0] MODE_OFS [2] = '{OFS_PAIR_MODE, OFS_THRD_MODE};
  localparam logic [7:0] CONF_OFS [2] = '{OFS_PAIR_CONF, OFS_THRD_CONF};

  // status bits: set-point codes that software should never have written
  logic [5:0] bad_code;

  always_comb
  begin
    // zero-wait slave: answer lands the cycle after setup, in the access phase
    acc       = i_psel && i_penable && ready_r;
    wr        = acc && i_pwrite;
    hit       = 1'b0;
    sp_nxt    = sp_r;
    mode_nxt  = mode_r;
    conf_nxt  = conf_r;
    en_nxt    = en_r;
    rdata_nxt = 32'h0;
    ready_nxt = i_psel && !i_penable;
    err_nxt   = 1'b0;
    for (int i = 0; i < 6; i++)
      bad_code[i] = sp_r[i] < SETPOINT_MIN_OK;
    for (int i = 0; i < 6; i++)
    begin
      if (i_paddr == SP_OFS[i])
      begin
        hit       = 1'b1;
        rdata_nxt = {26'h0, sp_r[i]};
        if (wr)
          sp_nxt[i] = i_pwdata[5:0];
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      if (i_paddr == MODE_OFS[i])
      begin
        hit       = 1'b1;
        rdata_nxt = {26'h0, mode_r[i]};
        if (wr)
          mode_nxt[i] = i_pwdata[5:0];
      end
      if (i_paddr == CONF_OFS[i])
      begin
        hit       = 1'b1;
        rdata_nxt = {24'h0, conf_r[i]};
        if (wr)
          conf_nxt[i] = switching_config_t'(i_pwdata[7:0]);
      end
    end
    if (i_paddr == OFS_CTRL)
    begin
      hit       = 1'b1;
      rdata_nxt = {30'h0, en_r};
      if (wr)
        en_nxt = i_pwdata[1:0];
    end
    if (i_paddr == OFS_STATUS)
    begin
      hit       = 1'b1;
      rdata_nxt = {24'h0, bad_code, grp_r};
    end
    if (!hit)
      err_nxt = i_psel && !i_penable;
    if (!(i_psel && !i_penable) || i_pwrite)
      rdata_nxt = 32'h0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 6; i++)
        sp_r[i] <= SETPOINT_RST;
      for (int i = 0; i < 2; i++)
      begin
        mode_r[i] <= MODE_RST;
        conf_r[i] <= switching_config_t'(CONF_RST);
      end
      en_r    <= 2'h0;
      rdata_r <= 32'h0;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end
    else
    begin
      sp_r    <= sp_nxt;
      mode_r  <= mode_nxt;
      conf_r  <= conf_nxt;
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  assign o_prdata  = rdata_r;
  assign o_pready  = ready_r;
  assign o_pslverr = err_r;

  // ==========================================
  // grouping steer and set-point selection
  node_drive_t  pair_dr;
  node_drive_t  third_dr;
  node_drive_t  second_dr;
  power_state_t pst;
  logic [5:0]   psp_nxt;
  logic [5:0]   tsp_nxt;

  always_comb
  begin
    pair_dr  = '{conf_r[0].voltage_slew_speed, conf_r[0].phase, conf_r[0].frequency_select};
    third_dr = '{conf_r[1].voltage_slew_speed, conf_r[1].phase, conf_r[1].frequency_select};
    if (grp_r == GRP_ALL_ONE)
      pair_dr = third_dr;
    second_dr = pair_dr;
    if (grp_r == GRP_PAIR_DUAL)
      second_dr.phase = 2'(pair_dr.phase + PHASE_HALF);
    pst = pin_s2_r[0] ? PST_SLEEP : (pin_s2_r[1] ? PST_STANDBY : PST_NORMAL);
    unique case (pst)
      PST_NORMAL:  begin psp_nxt = sp_r[0]; tsp_nxt = sp_r[3]; end
      PST_STANDBY: begin psp_nxt = sp_r[1]; tsp_nxt = sp_r[4]; end
      default:     begin psp_nxt = sp_r[2]; tsp_nxt = sp_r[5]; end
    endcase
    if (grp_r == GRP_ALL_ONE)
      psp_nxt = tsp_nxt;                     // one output, third's controls
  end

  // ==========================================
  // 5 MHz base tick (10 MHz reference divided by 2) shared by all nodes so phases stay aligned
  localparam logic [3:0] TICK_DIV = 4'(TICKS_PER_1M / 4);
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic       tick;
  always_comb
  begin
    tick    = (div_r == 4'(TICK_DIV - 4'h1));
    div_nxt = tick ? 4'h0 : 4'(div_r + 4'h1);
  end

  // ==========================================
  // registered outputs
  node_drive_t pdrv_r;
  node_drive_t sdrv_r;
  node_drive_t tdrv_r;
  logic [5:0]  psp_r;
  logic [5:0]  tsp_r;
  logic [10:0] pmv_r;
  logic [10:0] tmv_r;
  logic [1:0]  oen_r;
  logic [5:0]  pmode_r;
  logic [5:0]  tmode_r;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_r   <= 4'h0;
      pdrv_r  <= '0;
      sdrv_r  <= '0;
      tdrv_r  <= '0;
      psp_r   <= SETPOINT_RST;
      tsp_r   <= SETPOINT_RST;
      pmv_r   <= MV_BASE;
      tmv_r   <= MV_BASE;
      oen_r   <= 2'h0;
      pmode_r <= MODE_RST;
      tmode_r <= MODE_RST;
    end
    else
    begin
      div_r   <= div_nxt;
      pdrv_r  <= pair_dr;
      sdrv_r  <= second_dr;
      tdrv_r  <= third_dr;
      psp_r   <= psp_nxt;
      tsp_r   <= tsp_nxt;
      pmv_r   <= 11'(MV_BASE + 11'(psp_nxt) * MV_STEP);
      tmv_r   <= 11'(MV_BASE + 11'(tsp_nxt) * MV_STEP);
      oen_r   <= (grp_r == GRP_ALL_ONE) ? {en_r[1], en_r[1]} : en_r;
      pmode_r <= (grp_r == GRP_ALL_ONE) ? mode_r[1] : mode_r[0];
      tmode_r <= mode_r[1];
    end
  end

  assign o_pair_drive      = pdrv_r;
  assign o_third_drive     = tdrv_r;
  assign o_pair_setpoint   = psp_r;
  assign o_third_setpoint  = tsp_r;
  assign o_pair_target_mv  = pmv_r;
  assign o_third_target_mv = tmv_r;
  assign o_pair_enable     = oen_r[0];
  assign o_third_enable    = oen_r[1];
  assign o_pair_mode       = pmode_r;
  assign o_third_mode      = tmode_r;

  node_phase_gen u_first (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_drive    (pdrv_r),
    .o_node_clk (o_pair_node_first)
  );
  node_phase_gen u_second (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_drive    (sdrv_r),
    .o_node_clk (o_pair_node_second)
  );
  node_phase_gen u_third (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_drive    (tdrv_r),
    .o_node_clk (o_third_node)
  );

endmodule // buck_group_ctrl

// [include/buck_group_pkg.sv]
// package: register map, field layout and encodings for the buck group control
// ==========================================
// How it works
// - with the third node independent, pair and third output keep their own three set-points, mode and enable.
// - pair single phase drives both pair nodes from the pair config; the third node uses its own config.
// - pair dual phase runs the two pair nodes 180 degrees apart on their own, sharing pair frequency and slew.
// - a 6-bit set-point code maps to 300 mV plus 25 mV per step, up to 1875 mV.
// - each output has normal, standby and sleep set-point fields, chosen by the power state.
// - a 2-bit one-time grouping field picks all-as-one, pair single, pair dual, or reserved.
// - in all-as-one grouping all three nodes run from the third output's config.
// - frequency field 00 is 625 kHz, 01 is 1.25 MHz, 10 is 2.5 MHz, 11 reserved.
package buck_group_pkg;

  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_PAIR_NORM  = 8'h80;
  localparam logic [7:0] OFS_PAIR_STBY  = 8'h84;
  localparam logic [7:0] OFS_PAIR_SLEEP = 8'h88;
  localparam logic [7:0] OFS_PAIR_MODE  = 8'h8C;
  localparam logic [7:0] OFS_PAIR_CONF  = 8'h90;
  localparam logic [7:0] OFS_THRD_NORM  = 8'hB8;
  localparam logic [7:0] OFS_THRD_STBY  = 8'hBC;
  localparam logic [7:0] OFS_THRD_SLEEP = 8'hC0;
  localparam logic [7:0] OFS_THRD_MODE  = 8'hC4;
  localparam logic [7:0] OFS_THRD_CONF  = 8'hC8;
  localparam logic [7:0] OFS_CTRL       = 8'hD0;
  localparam logic [7:0] OFS_STATUS     = 8'hD4;

  // ==========================================
  // reset values and field widths
  localparam logic [5:0] SETPOINT_RST   = 6'h00;
  localparam logic [5:0] MODE_RST       = 6'h08;
  localparam logic [7:0] CONF_RST       = 8'h00;
  localparam logic [5:0] SETPOINT_MIN_OK = 6'h0D;   // codes below are 0.6 V or less
  localparam logic [1:0] PHASE_HALF     = 2'h2;     // 180 degrees

  // ==========================================
  // set-point decode, millivolts
  localparam logic [10:0] MV_BASE = 11'h12C;        // 300 mV
  localparam logic [10:0] MV_STEP = 11'h019;        // 25 mV

  // ==========================================
  // timing: divider base for switching clocks
  localparam int REF_CLK_HZ   = 10_000_000;
  localparam int SW_1MHZ_HZ   = 1_000_000;
  localparam int TICKS_PER_1M = REF_CLK_HZ / SW_1MHZ_HZ;  // one 1 MHz period in ref cycles

  typedef enum logic [1:0] {GRP_ALL_ONE, GRP_PAIR_SINGLE, GRP_PAIR_DUAL, GRP_RESERVED} grouping_t;
  typedef enum logic [1:0] {FREQ_1M, FREQ_2M, FREQ_4M, FREQ_RSVD} frequency_select_t;
  typedef enum logic [1:0] {PST_NORMAL, PST_STANDBY, PST_SLEEP} power_state_t;

  // configuration register layout
  typedef struct packed {
    logic [1:0]        voltage_slew_speed;
    logic [1:0]        phase;
    frequency_select_t frequency_select;
    logic              unused;
    logic              ilim_low;
  } switching_config_t;

  // what one switching node is given
  typedef struct packed {
    logic [1:0]        voltage_slew_speed;
    logic [1:0]        phase;
    frequency_select_t frequency_select;
  } node_drive_t;

endpackage

// [core/node_phase_gen.sv]
// one switching-node clock: frequency from a base tick, phase as quarter-period offset
`timescale 1ns/10ps
module node_phase_gen
  import buck_group_pkg::*;
(
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // settings
  input  wire logic         i_tick,
  input  wire node_drive_t  i_drive,
  // node clock
  output logic              o_node_clk
);

  // ==========================================
  // 8-step phase counter; 5 MHz ticks step it
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] pos;
  logic       clk_nxt;
  logic       clk_r;

  always_comb
  begin
    cnt_nxt = i_tick ? 3'(cnt_r + 3'h1) : cnt_r;
    unique case (i_drive.frequency_select)
      FREQ_1M: pos = 3'(cnt_r + {i_drive.phase, 1'b0});
      FREQ_2M: pos = 3'({cnt_r[1:0], 1'b0} + {i_drive.phase, 1'b0});
      FREQ_4M: pos = 3'({cnt_r[0], 2'h0} + {i_drive.phase[1], 2'h0});   // quarter steps fall between ticks
      default: pos = 3'h0;                    // reserved holds the node idle
    endcase
    clk_nxt = (i_drive.frequency_select == FREQ_RSVD) ? 1'b0 : ~pos[2];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cnt_r <= 3'h0;
      clk_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign o_node_clk = clk_r;

endmodule // node_phase_gen

// [testbench/buck_group_properties.sv]
// checker: port-level properties of the buck group control
`timescale 1ns/10ps
module buck_group_properties
  import buck_group_pkg::*;
(
  // clock, reset, apb
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // grouping and outputs
  input wire logic [1:0]  i_grouping_select,
  input wire logic        o_pair_node_first,
  input wire logic        o_pair_node_second,
  input wire logic        o_third_node,
  input wire logic [5:0]  o_pair_setpoint,
  input wire logic [5:0]  o_third_setpoint,
  input wire logic [10:0] o_pair_target_mv,
  input wire logic [10:0] o_third_target_mv,
  input wire logic        o_pair_enable
);
  // ====
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_ctrl_wr;
    i_psel && i_penable && o_pready && i_pwrite && (i_paddr == OFS_CTRL);
  endsequence
  property p_ready_next;
    s_setup |=> o_pready;
  endproperty
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  property p_err_ready;
    o_pslverr |-> o_pready;
  endproperty
  property p_rdata_idle;
    !o_pready |-> (o_prdata == 32'h0);
  endproperty
  property p_pair_mv;
    o_pair_target_mv == MV_BASE + MV_STEP * {5'h00, o_pair_setpoint};
  endproperty
  property p_third_mv;
    o_third_target_mv == MV_BASE + MV_STEP * {5'h00, o_third_setpoint};
  endproperty
  property p_pair_nodes;
    (i_grouping_select != 2'h2) |-> (o_pair_node_first == o_pair_node_second);
  endproperty
  property p_all_nodes;
    (i_grouping_select == 2'h0) |-> (o_third_node == o_pair_node_first);
  endproperty
  property p_all_mirror;
    (i_grouping_select == 2'h0) |-> (o_pair_setpoint == o_third_setpoint);
  endproperty
  // output lags the register by one edge, so look two samples on
  property p_indep_enable;
    s_ctrl_wr ##0 (i_grouping_select != 2'h0) |-> ##2 (o_pair_enable == $past(i_pwdata[0], 2));
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  a_pair_mv: assert property (p_pair_mv) else $error("pair target wrong");
  a_third_mv: assert property (p_third_mv) else $error("third target wrong");
  a_pair_nodes: assert property (p_pair_nodes) else $error("pair nodes differ");
  a_all_nodes: assert property (p_all_nodes) else $error("third node differs");
  a_all_mirror: assert property (p_all_mirror) else $error("set-point not shared");
  a_indep_enable: assert property (p_indep_enable) else $error("pair enable wrong");
endmodule // buck_group_properties

bind buck_group_ctrl buck_group_properties buck_group_properties_inst (.*);

// [testbench/buck_group_phase_and_setpoint_control_tb.sv]
// testbench: registers, grouping steer, set-point select and pair phasing
`timescale 1ns/10ps
module buck_group_phase_and_setpoint_control_tb;
  import buck_group_pkg::*;
  // ====
  // signals
  logic        i_ref_clk;
  logic        i_rst;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [1:0]  i_grouping_select;
  logic        i_standby;
  logic        i_sleep;
  logic        o_pair_node_first;
  logic        o_pair_node_second;
  logic        o_third_node;
  node_drive_t o_pair_drive;
  node_drive_t o_third_drive;
  logic [5:0]  o_pair_setpoint;
  logic [5:0]  o_third_setpoint;
  logic [10:0] o_pair_target_mv;
  logic [10:0] o_third_target_mv;
  logic        o_pair_enable;
  logic        o_third_enable;
  logic [5:0]  o_pair_mode;
  logic [5:0]  o_third_mode;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [15:0] lfsr_r = 16'h0026;
  logic [7:0]  val [10];
  logic [1:0]  ctrl;
  logic [31:0] q;
  logic        e;
  localparam logic [7:0] OFS [10] = '{OFS_PAIR_NORM, OFS_PAIR_STBY, OFS_PAIR_SLEEP, OFS_PAIR_MODE,
    OFS_PAIR_CONF, OFS_THRD_NORM, OFS_THRD_STBY, OFS_THRD_SLEEP, OFS_THRD_MODE, OFS_THRD_CONF};

  buck_group_ctrl buck_group_ctrl_inst (.*);

  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // ====
  // helpers
  function automatic logic [10:0] exp_mv(input logic [5:0] c);
    return MV_BASE + MV_STEP * {5'h00, c};
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // master waits for pready, never assumes the latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 50)
      err_total++;
  endtask

  task automatic do_reset(input int n);
    i_rst <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask

  // both pins high is sleep: sleep wins
  task automatic check_all(input logic [1:0] g);
    logic [5:0] ps;
    logic [5:0] ts;
    int         k;
    for (int st = 0; st < 4; st++)
    begin
      i_standby <= (st == 1 || st == 3);
      i_sleep <= (st >= 2);
      repeat (5) @(posedge i_ref_clk);
      k = (st == 1) ? 1 : ((st >= 2) ? 2 : 0);
      ts = val[5 + k][5:0];
      ps = (g == 2'h0) ? ts : val[k][5:0];
      chk("pair_setpoint", ps, o_pair_setpoint);
      chk("third_setpoint", ts, o_third_setpoint);
      chk("pair_mv", exp_mv(ps), o_pair_target_mv);
      chk("third_mv", exp_mv(ts), o_third_target_mv);
    end
    chk("pair_drive", (g == 2'h0) ? val[9][7:2] : val[4][7:2], o_pair_drive);
    chk("third_drive", val[9][7:2], o_third_drive);
    chk("pair_mode", (g == 2'h0) ? val[8][5:0] : val[3][5:0], o_pair_mode);
    chk("third_mode", val[8][5:0], o_third_mode);
    chk("pair_enable", (g == 2'h0) ? ctrl[1] : ctrl[0], o_pair_enable);
    chk("third_enable", ctrl[1], o_third_enable);
  endtask

  // second node must rise half a period after the first
  task automatic phase_check();
    int   n;
    int   d;
    logic pf;
    logic ps;
    n = 0;
    d = 0;
    do
    begin
      pf = o_pair_node_first;
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (!(o_pair_node_first && !pf) && n < 100);
    n = 0;
    do
    begin
      pf = o_pair_node_first;
      ps = o_pair_node_second;
      @(posedge i_ref_clk);
      #1;
      n++;
      if (o_pair_node_second && !ps)
        d = n;
    end while (!(o_pair_node_first && !pf) && n < 100);
    chk("half_period", n / 2, d);
  endtask

  // ====
  // tests
  initial
  begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_grouping_select = 2'h0;
    i_standby = 1'b0;
    i_sleep = 1'b0;
    do_reset(2);
    for (int g = 0; g < 3; g++)
    begin
      i_grouping_select <= g[1:0];
      do_reset(4);
      for (int i = 0; i < 10; i++)
      begin
        apb(1'b0, OFS[i], 32'h0);
        chk("reset_value", (i % 5 == 3) ? 32'h8 : 32'h0, q);
        lfsr_r = lfsr_step(lfsr_r);
        val[i] = lfsr_r[7:0];
        if (i % 5 < 3)
          val[i][5:0] = 6'h0D + lfsr_r[13:8] % 51;
        if (i == g)
          val[i][5:0] = 6'h0C;
        if (i == g + 5)
          val[i][5:0] = 6'h0D;
        if (i % 5 == 4 && val[i][3:2] == 2'h3)
          val[i][3:2] = 2'h2;
        apb(1'b1, OFS[i], {24'hFFFFFF, val[i]});
        apb(1'b0, OFS[i], 32'h0);
        chk("readback", val[i] & ((i % 5 == 4) ? 8'hFF : 8'h3F), q);
      end
      lfsr_r = lfsr_step(lfsr_r);
      ctrl = lfsr_r[1:0] | ((g == 2) ? 2'h3 : 2'h0);
      apb(1'b1, OFS_CTRL, {30'h0, ctrl});
      apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status", {val[7][5:0] < 13, val[6][5:0] < 13, val[5][5:0] < 13, val[2][5:0] < 13,
        val[1][5:0] < 13, val[0][5:0] < 13, g[1:0]}, q);
      apb(1'b0, 8'h00, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, q);
      check_all(g[1:0]);
      if (g == 2)
        phase_check();
      $display("grouping %0d done", g);
    end
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    report_and_stop();
  end
endmodule // buck_group_phase_and_setpoint_control_tb
